// [shared/apcc_cfg.svh]
// Register offsets, bit positions, reset values and timing counts.
// Assumes inclusion by bare name from any file that needs them.
`ifndef APCC_CFG_SVH
`define APCC_CFG_SVH
// ==========================================================
// Register offsets
`define APCC_ADDR_CONV 16'h1d26
`define APCC_ADDR_PGC 16'h1d27
`define APCC_ADDR_CMC 16'h1d28
`define APCC_ADDR_ETC 16'h1d29
`define APCC_RST_REG 8'h00
// ==========================================================
// Bit positions
`define APCC_B_ENABLE 7
`define APCC_B_RETRIG 6
`define APCC_B_START 0
`define APCC_B_PCH_POL 7
`define APCC_B_INV2 6
`define APCC_B_GRD_POL 5
`define APCC_B_CAP_ONLY 1
`define APCC_B_DBL 0
`define APCC_B_PREV_SRC 7
`define APCC_B_CLR 3
`define APCC_B_STOP_TH 3
`define APCC_F3_HI_HI 6
`define APCC_F3_HI_LO 4
`define APCC_F3_LO_HI 2
`define APCC_F3_LO_LO 0
// Writable masks, unused bits read zero
`define APCC_MASK_PGC 8'he3
`define APCC_MASK_ETC 8'h7f
// ==========================================================
// Timing: countdown loaded by a clear command; it stays pending one cycle longer
`define APCC_CLR_CYCLES 4'h3
`endif

// [shared/apcc_pkg.sv]
// Types shared by the computation control block.
// Assumes apcc_cfg.svh supplies the numeric constants.
package apcc_pkg;
  // ==========================================================
  // Modes, error codes, sequencer states
  typedef enum logic [2:0] {
    APCC_MD_BASIC = 3'b000, APCC_MD_ACC = 3'b001, APCC_MD_AVG = 3'b010,
    APCC_MD_BURST = 3'b011, APCC_MD_LPF = 3'b100
  } apcc_mode_t;
  typedef enum logic [2:0] {
    APCC_E_RES_PREV = 3'b000, APCC_E_RES_SET = 3'b001, APCC_E_RES_FLT = 3'b010,
    APCC_E_PREV_FLT = 3'b100, APCC_E_FLT_SET = 3'b101
  } apcc_error_calculation_select_t;
  typedef enum logic [1:0] {
    APCC_S_IDLE = 2'b00, APCC_S_CONV = 2'b01, APCC_S_ERROR_CALCULATION_SELECT = 2'b10, APCC_S_DECIDE = 2'b11
  } apcc_state_t;
  // ==========================================================
  // Carriers
  typedef struct packed {
    apcc_mode_t mode;
    logic [2:0] shift;
    apcc_error_calculation_select_t error_calculation_select;
    logic dbl;
  } apcc_cfg_t;
  typedef struct packed {
    logic pin_en;
    logic pin_high;
    logic hold_en;
    logic hold_high;
    logic guard_a;
    logic guard_b;
  } apcc_pch_t;
endpackage

// [design/apcc_compute.sv]
// Accumulator, filter and error arithmetic of the computation unit.
// Assumes go is a one-cycle pulse from the sequencer and clear a one-cycle pulse from the clear command.
`timescale 1ns/1ps
`include "apcc_cfg.svh"
module apcc_compute import apcc_pkg::*; #(
  parameter int DATA_W = 16,
  parameter int ACC_W = 18
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire apcc_cfg_t i_cfg,
  input wire logic i_go,
  input wire logic i_clear,
  input wire logic [DATA_W-1:0] i_result,
  input wire logic [DATA_W-1:0] i_previous,
  input wire logic [DATA_W-1:0] i_setpoint,
  input wire logic [7:0] i_repeat_target,
  output logic [DATA_W-1:0] o_filter,
  output logic [DATA_W-1:0] o_error,
  output logic [ACC_W-1:0] o_acc,
  output logic [7:0] o_count,
  output logic o_overflow
);
  initial if (ACC_W <= DATA_W) $error("ACC_W must exceed DATA_W");
  // ==========================================================
  // Arithmetic, all combinational
  wire [ACC_W:0] acc_sum = {1'b0, o_acc} + {{(ACC_W+1-DATA_W){1'b0}}, i_result};
  wire [ACC_W-1:0] acc_shr = acc_sum[ACC_W-1:0] >> i_cfg.shift;
  wire signed [DATA_W:0] lpf_diff = $signed({1'b0, i_result}) - $signed({1'b0, o_filter});
  wire signed [DATA_W:0] lpf_step = lpf_diff >>> i_cfg.shift;
  wire [7:0] count_inc = o_count + 8'h01;
  wire count_hit = count_inc >= i_repeat_target;
  wire accumulating = (i_cfg.mode == APCC_MD_ACC) || (i_cfg.mode == APCC_MD_AVG) ||
    (i_cfg.mode == APCC_MD_BURST);
  // Shift is ignored in basic and reserved modes, filter holds
  wire [DATA_W-1:0] next_filter = accumulating ? acc_shr[DATA_W-1:0] :
    (i_cfg.mode == APCC_MD_LPF) ? o_filter + lpf_step[DATA_W-1:0] : o_filter;
  // Double sampling subtracts the first sample before the reference
  wire [DATA_W-1:0] res_base = i_cfg.dbl ? i_result - i_previous : i_result;
  logic [DATA_W-1:0] next_error;
  // Error selection; reserved codes keep the last error
  always_comb begin
    case (i_cfg.error_calculation_select)
      APCC_E_RES_PREV: next_error = i_result - i_previous;
      APCC_E_RES_SET: next_error = res_base - i_setpoint;
      APCC_E_RES_FLT: next_error = res_base - next_filter;
      APCC_E_PREV_FLT: next_error = i_previous - next_filter;
      APCC_E_FLT_SET: next_error = next_filter - i_setpoint;
      default: next_error = o_error;
    endcase
  end
  // ==========================================================
  // State update
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_filter <= '0;
      o_error <= '0;
      o_acc <= '0;
      o_count <= 8'h00;
      o_overflow <= 1'b0;
    end else begin
      if (i_go) begin
        o_filter <= next_filter;
        o_error <= next_error;
      end
      // Clear wins for counters; a fresh overflow wins over clear
      if (i_clear) begin
        o_acc <= '0;
        o_count <= 8'h00;
      end else if (i_go && accumulating) begin
        o_acc <= (i_cfg.mode != APCC_MD_ACC && count_hit) ? '0 : acc_sum[ACC_W-1:0];
        o_count <= (i_cfg.mode != APCC_MD_ACC && count_hit) ? 8'h00 : count_inc;
      end
      if (i_go && accumulating && acc_sum[ACC_W]) begin
        o_overflow <= 1'b1;
      end else if (i_clear) begin
        o_overflow <= 1'b0;
      end
    end
  end
  // ==========================================================
  // Checks
  basic_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_go && !i_clear && i_cfg.mode == APCC_MD_BASIC) |=> $stable(o_acc) && $stable(o_filter))
    else $error("basic mode changed computation");
  reserved_err_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_go && (i_cfg.error_calculation_select == 3'b011 || i_cfg.error_calculation_select[2:1] == 2'b11)) |=> $stable(o_error))
    else $error("reserved error code changed error");
  clear_acc_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_clear && !i_go) |=> (o_acc == '0) && (o_count == 8'h00) && !o_overflow)
    else $error("clear left state behind");
endmodule

// [design/apcc_top.sv]
// Control registers, conversion sequencer and precharge drive of the converter.
// Assumes the analog core runs on i_ref_clk and answers each request with a done pulse.
// Functional notes
// - Precharge polarity sets pin and capacitor levels
// - Inverted option flips second conversion polarities
// - Without inversion both conversions share polarities
// - Guard outputs start at guard level
// - Capacitor-only option keeps pin undriven
// - Double sampling computes after each pair
// - Previous value copied at conversion start
// - Filter time constant two to shift
// - Accumulating modes shift result right
// - Basic and reserved modes ignore shift
// - Clear command empties accumulator, counter, overflow
// - Clear command self-clears when finished
// - Mode field selects five operating modes
// - Error select chooses difference for error
// - Double sampling subtracts first sample first
// - Paired error only after second sample
// - Stop option ends retrigger on threshold
// - Without stop, only software ends retrigger
// - Stop option inert without retrigger
// - Retrigger enable restarts after each trigger
// - Start needs enable, reads one while busy
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "apcc_cfg.svh"
module apcc_top import apcc_pkg::*; #(
  parameter int DATA_W = 16,
  parameter int ACC_W = 18
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [7:0] i_precharge_time,
  input wire logic [DATA_W-1:0] i_setpoint,
  input wire logic [7:0] i_repeat_count_target,
  input wire logic i_threshold_met,
  input wire logic i_acq_phase,
  input wire logic i_conv_done,
  input wire logic [DATA_W-1:0] i_conv_data,
  output logic o_conv_req,
  output logic o_second_sample,
  output apcc_pch_t o_pch,
  output logic [DATA_W-1:0] o_conversion_result,
  output logic [DATA_W-1:0] o_previous_value,
  output logic [DATA_W-1:0] o_filter_value,
  output logic [DATA_W-1:0] o_error_value,
  output logic [ACC_W-1:0] o_accumulator,
  output logic [7:0] o_sample_counter,
  output logic o_overflow
);
  initial if (DATA_W < 2) $error("DATA_W too small");

  // ==========================================================
  // Register storage
  logic enable; // Converter enable
  logic retrig; // Auto retrigger enable
  logic start; // Conversion start, busy while one
  logic [7:0] pgc; // Precharge and guard control
  logic [7:0] cmc; // Computation control without clear bit
  logic [7:0] etc; // Error and threshold control
  logic clr_pending; // Clear command in progress
  logic [3:0] clr_cnt; // Cycles left for clear
  logic clr_pulse; // One-cycle clear toward arithmetic
  apcc_state_t state; // Sequencer state
  logic [DATA_W-1:0] prev_q; // Previous value register

  // ==========================================================
  // Address decode
  wire hit_conv = (i_addr == `APCC_ADDR_CONV);
  wire hit_pgc = (i_addr == `APCC_ADDR_PGC);
  wire hit_cmc = (i_addr == `APCC_ADDR_CMC);
  wire hit_etc = (i_addr == `APCC_ADDR_ETC);
  wire wr_conv = i_wr && hit_conv;
  wire wr_cmc = i_wr && hit_cmc;
  wire clr_issue = wr_cmc && i_wdata[`APCC_B_CLR];
  // Start may only be set by a write that also sets enable; the old enable does not count
  wire new_enable = i_wdata[`APCC_B_ENABLE];
  wire start_set = wr_conv && i_wdata[`APCC_B_START] && new_enable;
  wire start_clr_sw = wr_conv && !i_wdata[`APCC_B_START];

  // ==========================================================
  // Field views
  wire pch_pol = pgc[`APCC_B_PCH_POL];
  wire inv2 = pgc[`APCC_B_INV2];
  wire grd_pol = pgc[`APCC_B_GRD_POL];
  wire cap_only = pgc[`APCC_B_CAP_ONLY];
  wire dbl = pgc[`APCC_B_DBL];
  wire prev_src = cmc[`APCC_B_PREV_SRC];
  wire stop_th = etc[`APCC_B_STOP_TH];
  apcc_cfg_t cfg;
  assign cfg.mode = apcc_mode_t'(cmc[`APCC_F3_LO_HI:`APCC_F3_LO_LO]);
  assign cfg.shift = cmc[`APCC_F3_HI_HI:`APCC_F3_HI_LO];
  assign cfg.error_calculation_select = apcc_error_calculation_select_t'(etc[`APCC_F3_HI_HI:`APCC_F3_HI_LO]);
  assign cfg.dbl = dbl;

  // ==========================================================
  // Read data, valid only in the cycle after the strobe
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (!i_rd) begin
      next_rdata = 8'h00;
    end else if (hit_conv) begin
      next_rdata = {enable, retrig, 5'h00, start};
    end else if (hit_pgc) begin
      next_rdata = pgc;
    end else if (hit_cmc) begin
      next_rdata = {cmc[7:4], clr_pending, cmc[2:0]};
    end else if (hit_etc) begin
      next_rdata = etc;
    end
  end

  // ==========================================================
  // Sequencer decisions
  wire in_conv = (state == APCC_S_CONV);
  wire first_done = in_conv && start && i_conv_done && dbl && !o_second_sample;
  wire pair_done = in_conv && start && i_conv_done && !first_done;
  // Stop on threshold only matters when retrigger is on
  wire stop_now = stop_th && i_threshold_met;
  wire again = (state == APCC_S_DECIDE) && retrig && start && !stop_now;
  wire hw_clear = (state == APCC_S_DECIDE) && !again;
  wire conv_begin = ((state == APCC_S_IDLE) && start && enable) || first_done || again;
  apcc_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      APCC_S_IDLE: begin
        if (start && enable) begin
          next_state = APCC_S_CONV;
        end
      end
      APCC_S_CONV: begin
        // Software abort drops the pair with no computation
        if (!start) begin
          next_state = APCC_S_IDLE;
        end else if (pair_done) begin
          next_state = APCC_S_ERROR_CALCULATION_SELECT;
        end
      end
      APCC_S_ERROR_CALCULATION_SELECT: next_state = APCC_S_DECIDE;
      APCC_S_DECIDE: next_state = again ? APCC_S_CONV : APCC_S_IDLE;
      default: next_state = APCC_S_IDLE;
    endcase
  end

  // ==========================================================
  // Precharge and guard drive; second of a pair may be inverted
  wire flip = dbl && inv2 && o_second_sample;
  wire pch_stage = in_conv && !i_acq_phase;
  wire pch_on = pch_stage && (|i_precharge_time);
  wire grd_base = grd_pol ^ flip;
  apcc_pch_t next_pch;
  assign next_pch.pin_en = pch_on && !cap_only;
  assign next_pch.pin_high = pch_on && (pch_pol ^ flip);
  assign next_pch.hold_en = pch_on;
  assign next_pch.hold_high = pch_on && !(pch_pol ^ flip);
  assign next_pch.guard_a = grd_base ^ (in_conv && i_acq_phase);
  assign next_pch.guard_b = grd_base;

  // ==========================================================
  // Control registers and start bit
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      enable <= 1'b0;
      retrig <= 1'b0;
      start <= 1'b0;
      pgc <= `APCC_RST_REG;
      cmc <= `APCC_RST_REG;
      etc <= `APCC_RST_REG;
    end else begin
      if (wr_conv) begin
        enable <= new_enable;
        retrig <= i_wdata[`APCC_B_RETRIG];
      end
      if (i_wr && hit_pgc) begin
        pgc <= i_wdata & `APCC_MASK_PGC;
      end
      if (wr_cmc) begin
        cmc <= {i_wdata[7:4], 1'b0, i_wdata[2:0]};
      end
      if (i_wr && hit_etc) begin
        etc <= i_wdata & `APCC_MASK_ETC;
      end
      // Software set wins over the hardware clear
      if (start_set) begin
        start <= 1'b1;
      end else if (start_clr_sw || hw_clear) begin
        start <= 1'b0;
      end
    end
  end

  // Clear command runs a few cycles so software sees it pending
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      clr_pending <= 1'b0;
      clr_cnt <= 4'h0;
      clr_pulse <= 1'b0;
    end else begin
      clr_pulse <= clr_issue;
      if (clr_issue) begin
        clr_pending <= 1'b1;
        clr_cnt <= `APCC_CLR_CYCLES;
      end else if (clr_cnt != 4'h0) begin
        clr_cnt <= clr_cnt - 4'h1;
      end else begin
        clr_pending <= 1'b0;
      end
    end
  end

  // Sequencer, result capture and outputs
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state <= APCC_S_IDLE;
      o_conv_req <= 1'b0;
      o_second_sample <= 1'b0;
      o_conversion_result <= '0;
      prev_q <= '0;
      o_pch <= '0;
      o_rdata <= 8'h00;
    end else begin
      state <= next_state;
      o_conv_req <= conv_begin;
      o_pch <= next_pch;
      o_rdata <= next_rdata;
      if (first_done) begin
        o_second_sample <= 1'b1;
      end else if (!in_conv || !start) begin
        o_second_sample <= 1'b0;
      end
      if (in_conv && i_conv_done) begin
        o_conversion_result <= i_conv_data;
      end
      if (conv_begin) begin
        // The first of a pair is latched on this same edge, so take it straight from the core
        prev_q <= prev_src ? o_filter_value : (first_done ? i_conv_data : o_conversion_result);
      end
    end
  end
  assign o_previous_value = prev_q;

  // ==========================================================
  // Arithmetic unit
  apcc_compute #(
    .DATA_W(DATA_W),
    .ACC_W(ACC_W)
  ) u_compute (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_cfg(cfg),
    .i_go(state == APCC_S_ERROR_CALCULATION_SELECT),
    .i_clear(clr_pulse),
    .i_result(o_conversion_result),
    .i_previous(prev_q),
    .i_setpoint(i_setpoint),
    .i_repeat_target(i_repeat_count_target),
    .o_filter(o_filter_value),
    .o_error(o_error_value),
    .o_acc(o_accumulator),
    .o_count(o_sample_counter),
    .o_overflow(o_overflow)
  );

  // ==========================================================
  // Checks
  sequence clr_cmd_s;
    clr_issue;
  endsequence
  sequence clr_finish_s;
    clr_pending ##[1:8] !clr_pending;
  endsequence
  clr_self_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    clr_cmd_s |=> clr_finish_s)
    else $error("clear command never finished");
  start_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (wr_conv && !new_enable && !start) |=> !start)
    else $error("start set without enable");
  busy_read_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_rd && hit_conv && start) |=> o_rdata[`APCC_B_START])
    else $error("start not visible while busy");
  pair_error_calculation_select_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (in_conv && start && i_conv_done && dbl && !o_second_sample) |=> (state == APCC_S_CONV) && o_conv_req)
    else $error("first of pair was computed");
  prev_copy_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (conv_begin && prev_src) |=> (prev_q == $past(o_filter_value)))
    else $error("previous value not from filter");
  cap_only_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (cap_only || !(|i_precharge_time)) |=> !o_pch.pin_en)
    else $error("pin driven in capacitor-only precharge");
  pol_second_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (pch_on && dbl && inv2 && o_second_sample) |=> (o_pch.pin_high != $past(pch_pol)) && o_pch.hold_high == $past(pch_pol))
    else $error("second precharge not inverted");
  stop_th_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ((state == APCC_S_DECIDE) && retrig && stop_now && !start_set) |=> !start && (state == APCC_S_IDLE))
    else $error("stop on threshold did not stop");
  keep_start_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ((state == APCC_S_DECIDE) && retrig && !stop_th && start && !wr_conv) |=> start && o_conv_req)
    else $error("hardware cleared start without stop");
  auto_retrigger_enable_off_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ((state == APCC_S_DECIDE) && !retrig && !start_set) |=> !start)
    else $error("start kept without retrigger");
endmodule

// [verif/apcc_core_model.sv]
// Behavioural model of the analog sample-and-hold and conversion core.
// Assumes one-cycle requests on the reference clock and a fixed latency.
`timescale 1ns/1ps
module apcc_core_model #(
  parameter int DATA_W = 16,
  parameter int LAT = 10
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic [DATA_W-1:0] i_val0,
  input wire logic [DATA_W-1:0] i_val1,
  output logic o_acq,
  output logic o_done,
  output logic [DATA_W-1:0] o_data
);
  int cnt; // Cycles since the request, 0 when idle
  logic pick; // Alternates the value source per conversion
  // ==========================================================
  // Precharge for the first half of the latency, acquisition after it
  assign o_acq = (cnt > LAT / 2);
  // ==========================================================
  // Conversion timer; data is only meaningful beside the done pulse
  always @(posedge i_ref_clk) begin
    o_done <= 1'b0;
    o_data <= ~o_data; // Released bus keeps changing so a stale value never matches
    if (i_rst) begin
      cnt <= 0;
      pick <= 1'b0;
      o_data <= '0;
    end else if (cnt == LAT) begin
      cnt <= 0;
      o_done <= 1'b1;
      o_data <= pick ? i_val1 : i_val0;
      pick <= ~pick;
    end else if (cnt != 0 || i_req) begin
      cnt <= cnt + 1;
    end
  end
endmodule

// [verif/apcc_top_tb.sv]
// Self-checking bench for the converter control block.
// Assumes the core model answers each request after a fixed latency.
`timescale 1ns/1ps
`include "apcc_cfg.svh"
module apcc_top_tb;
  import apcc_pkg::*;
  localparam logic [15:0] A_CON = `APCC_ADDR_CONV;
  localparam logic [15:0] A_PGC = `APCC_ADDR_PGC;
  localparam logic [15:0] A_CMC = `APCC_ADDR_CMC;
  localparam logic [15:0] A_ETC = `APCC_ADDR_ETC;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] pre_time = 8'h00;
  logic [15:0] sp = 16'h0100;
  logic [7:0] rpt = 8'h04;
  logic thr = 1'b0;
  logic [15:0] v0 = 16'h03e8;
  logic [15:0] v1 = 16'h0514;
  logic acq, done, req, second, ovf;
  logic [7:0] rdata, cnt;
  logic [15:0] cdata, res, prev, flt, err;
  logic [17:0] acc;
  apcc_pch_t pch;
  int n_errors = 0;
  int checked = 0;
  int n_req = 0;
  // ==========================================================
  // Clock and request counter
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (req === 1'b1) begin
      n_req <= n_req + 1;
    end
  end
  apcc_top dut_u (.i_ref_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_precharge_time(pre_time), .i_setpoint(sp), .i_repeat_count_target(rpt),
    .i_threshold_met(thr), .i_acq_phase(acq), .i_conv_done(done), .i_conv_data(cdata), .o_conv_req(req),
    .o_second_sample(second), .o_pch(pch), .o_conversion_result(res), .o_previous_value(prev),
    .o_filter_value(flt), .o_error_value(err), .o_accumulator(acc), .o_sample_counter(cnt), .o_overflow(ovf));
  apcc_core_model core_u (.i_ref_clk(clk), .i_rst(rst), .i_req(req), .i_val0(v0), .i_val1(v1),
    .o_acq(acq), .o_done(done), .o_data(cdata));
  // ==========================================================
  // Shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] e, input string what);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e, what);
  endtask
  task automatic restart();
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
  endtask
  // Polls the start bit; the read costs two cycles so the bound is generous
  task automatic conv(input logic [7:0] c);
    int i;
    wr_reg(A_CON, c);
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      addr <= A_CON;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      if (rdata[0] === 1'b0) break;
    end
    chk(i < 100, 1, "conversion end");
  endtask
  // Waits for a request, then looks inside its precharge stage
  task automatic pch_at(input logic [5:0] e, input logic [5:0] m);
    int i;
    for (i = 0; i < 60; i++) begin
      @(posedge clk);
      #1;
      if (req === 1'b1) break;
    end
    repeat (3) @(posedge clk);
    #1;
    chk({i < 60, pch & m}, {1'b1, e}, "precharge drive");
  endtask
  task automatic close_out();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic s_regs();
    restart();
    rchk(A_CON, 8'h00, "con reset");
    rchk(A_PGC, 8'h00, "pgc reset");
    rchk(A_CMC, 8'h00, "cmc reset");
    rchk(A_ETC, 8'h00, "etc reset");
    wr_reg(A_PGC, 8'hff);
    rchk(A_PGC, 8'he3, "pgc mask");
    wr_reg(A_ETC, 8'hff);
    rchk(A_ETC, 8'h7f, "etc mask");
    wr_reg(16'h1d2f, 8'hff);
    rchk(16'h1d2f, 8'h00, "unmapped");
    wr_reg(A_CON, 8'h01);
    rchk(A_CON, 8'h00, "start without enable");
  endtask
  // Basic mode keeps the filter at zero, so each code has a plain expectation
  task automatic s_err();
    logic [2:0] code [6] = '{3'd0, 3'd1, 3'd2, 3'd4, 3'd5, 3'd3};
    logic [15:0] e [6];
    e = '{v1 - v0, v1 - sp, v1, v0, -sp, 16'h0000};
    for (int i = 0; i < 6; i++) begin
      restart();
      wr_reg(A_ETC, {1'b0, code[i], 4'h0});
      conv(8'h81);
      conv(8'h81);
      chk(err, e[i], "error value");
      chk({res, prev}, {v1, v0}, "result and previous");
    end
  endtask
  task automatic s_acc();
    restart();
    wr_reg(A_CMC, 8'h21);
    conv(8'h81);
    conv(8'h81);
    chk({cnt, acc}, {8'd2, 18'd2300}, "accumulate");
    chk(flt, 16'd575, "shifted sum");
    wr_reg(A_CMC, 8'h29);
    rchk(A_CMC, 8'h29, "clear pending");
    repeat (6) @(posedge clk);
    rchk(A_CMC, 8'h21, "clear done");
    chk({ovf, cnt, acc}, 27'h0, "cleared");
    wr_reg(A_CMC, 8'h27);
    conv(8'h81);
    chk({cnt, acc}, 26'h0, "reserved mode");
    // Average then burst average: four samples, shift two, target four
    for (int m = 2; m < 4; m++) begin
      wr_reg(A_CMC, {5'b00100, m[2:0]});
      repeat (4) conv(8'h81);
      chk({cnt, acc}, 26'h0, "average restarts");
      chk(flt, 16'd1150, "average of four");
    end
  endtask
  task automatic s_lpf();
    restart();
    wr_reg(A_CMC, 8'ha4);
    conv(8'h81);
    chk(flt, 16'd250, "filter one");
    conv(8'h81);
    chk({prev, flt}, {16'd250, 16'd512}, "filter two");
  endtask
  task automatic s_dbl();
    int i;
    int base;
    restart();
    wr_reg(A_PGC, 8'h01);
    wr_reg(A_CMC, 8'h11);
    wr_reg(A_ETC, 8'h10);
    base = n_req;
    wr_reg(A_CON, 8'h81);
    for (i = 0; i < 60 && second !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk({i < 60, cnt, err}, {1'b1, 24'h0}, "first of pair");
    conv(8'h81);
    chk(n_req - base, 2, "pair requests");
    chk({cnt, err}, {8'd1, v1 - v0 - sp}, "pair result");
  endtask
  task automatic s_pch();
    restart();
    pre_time <= 8'h05;
    for (int i = 0; i < 8; i++) begin
      wr_reg(A_PGC, {i[0], 1'b0, i[1], 3'b000, i[2], 1'b0});
      wr_reg(A_CON, 8'h81);
      pch_at({~i[2], i[0], 1'b1, ~i[0], i[1], i[1]}, 6'h3f);
      repeat (5) @(posedge clk);
      #1;
      chk({pch.guard_a, pch.guard_b}, {~i[1], i[1]}, "guard in acquisition");
      conv(8'h81);
    end
    wr_reg(A_PGC, 8'hc1);
    wr_reg(A_CON, 8'h81);
    pch_at(6'b111000, 6'h3f);
    pch_at(6'b101111, 6'h3f);
    conv(8'h81);
    wr_reg(A_PGC, 8'h81);
    wr_reg(A_CON, 8'h81);
    pch_at(6'b111000, 6'h3f);
    pch_at(6'b111000, 6'h3f);
    conv(8'h81);
    pre_time <= 8'h00; // Zero time turns the drive off whatever the polarity
    wr_reg(A_CON, 8'h81);
    pch_at(6'b000000, 6'b101000);
    conv(8'h81);
  endtask
  task automatic s_auto_retrigger_enable();
    int base;
    restart();
    thr <= 1'b1;
    wr_reg(A_ETC, 8'h08);
    base = n_req;
    conv(8'hc1);
    chk(n_req - base, 1, "stop on threshold");
    wr_reg(A_ETC, 8'h00);
    base = n_req;
    wr_reg(A_CON, 8'hc1);
    repeat (60) @(posedge clk);
    rchk(A_CON, 8'hc1, "still running");
    chk(n_req - base > 2, 1, "retriggered");
    conv(8'hc0);
    base = n_req;
    repeat (30) @(posedge clk);
    chk(n_req - base, 0, "stopped by software");
    thr <= 1'b0;
    wr_reg(A_ETC, 8'h08);
    base = n_req;
    conv(8'h81);
    chk(n_req - base, 1, "single shot");
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    s_regs();
    s_err();
    s_acc();
    s_lpf();
    s_dbl();
    s_pch();
    s_auto_retrigger_enable();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    close_out();
  end
endmodule
